// file: common/pei_pkg.sv
// Constants, register map and field layout of the protection event and interrupt block.
// Assumes a 50 MHz clock and a classic Wishbone slave with 32-bit data.
// Behaviour
// R1: In power-save, scan cells one to fourteen automatically at the chosen interval.
// R2: Clearing power-save mid-scan lets the running scan finish through the last cell.
// R3: Host checks cell start bit is clear after leaving power-save before measuring.
// R4: Automatic power-save scans still set the cell completion request.
// R5: Host clears the cell completion interrupt enable before entering power-save.
// R6: Completed measurements and errors drive the active-low interrupt pin.
// R7: Two enable registers gate sources; two pending registers read and clear by write.
// R8: Cell measurement finish stores results and raises the cell completion request.
// R9: Current measurement finish stores result and raises the current completion request.
// R10: Temperature finish stores results and raises the temperature completion request.
// R11: Count overvoltage scans; at programmed count raise request and clear charge enable.
// R12: Short circuit with delay pin tripped raises request and clears both FET_CTRL_REG enables.
// R13: CRC mismatch raises the CRC request and discards that transfer's data.
// R14: Internal clock halt for a set period raises request and clears both FET_CTRL_REG enables.
// R15: No register access beyond the watchdog period raises watchdog request and interrupt.
// R16: Two consecutive watchdog overflows also clear both FET_CTRL_REG enables.
// R17: A register access failing CRC does not restart the watchdog counter.
// R18: Protection-cleared FET_CTRL_REG enables stay cleared until the host rewrites them.
// R19: Interrupt pin stays low while any enabled request is pending.
package pei_pkg;
   localparam int ADDR_W = 4;
   // Word byte addresses
   localparam logic [ADDR_W-1:0] A_CTRL   = 4'h0; // power save, start bits, FET_CTRL_REG enables
   localparam logic [ADDR_W-1:0] A_OVSET  = 4'h4; // scan interval, delay count
   localparam logic [ADDR_W-1:0] A_IRQEN  = 4'h8; // enable a (low byte), b (next byte)
   localparam logic [ADDR_W-1:0] A_IRQPND = 4'hC; // pending a and b, write one to clear
   // Control fields
   localparam int B_PSAVE = 0;
   localparam int B_CELL  = 1;
   localparam int B_CUR   = 2;
   localparam int B_TEMP  = 3;
   localparam int B_CHG   = 4;
   localparam int B_DIS   = 5;
   localparam int B_WDP   = 8;   // two-bit watchdog period field
   localparam int W_WDP   = 2;
   // Setup fields
   localparam int B_SLT   = 0;   // two-bit scan interval field
   localparam int W_SLT   = 2;
   localparam int B_CNT   = 4;   // four-bit delay count field
   localparam int W_CNT   = 4;
   // Event bits: group a is measurement done, group b is faults
   localparam int E_CELL = 0;
   localparam int E_CUR  = 1;
   localparam int E_TEMP = 2;
   localparam int E_OV   = 8;
   localparam int E_SC   = 9;
   localparam int E_CRC  = 10;
   localparam int E_CLK  = 11;
   localparam int E_WDT  = 12;
   localparam int N_EV   = 16;
   localparam logic [N_EV-1:0] EV_MASK = 16'h1F07;
   localparam int NUM_CELLS = 14;
   // Timing
   localparam int CLK_MHZ       = 50;
   localparam int SCAN_BASE_MS  = 100;  // scan interval unit
   localparam int WDT_BASE_MS   = 250;  // watchdog period unit
   localparam int CELL_US       = 2000; // per-cell measurement time
   localparam int CELL_CYC      = CELL_US * CLK_MHZ;
   localparam int SCAN_BASE_CYC = SCAN_BASE_MS * 1000 * CLK_MHZ;
   localparam int WDT_BASE_CYC  = WDT_BASE_MS * 1000 * CLK_MHZ;
endpackage

// file: rtl/pei_core.sv
// Event capture, interrupt gating, scan sequencing, overvoltage and watchdog logic.
// Assumes analog comparators and measurement engines drive the done and fault inputs
// synchronous to clk_i; the SPI framing feeds reg_access_i and crc_err_i.
`timescale 1ns/100ps
`default_nettype none
module pei_core
   import pei_pkg::*;
#(
   parameter int CELL_CYCLES = CELL_CYC,
   parameter int SCAN_UNIT   = SCAN_BASE_CYC,
   parameter int WDT_UNIT    = WDT_BASE_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic              wb_we_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              cell_done_i,
   input  wire logic              cell_over_i,
   input  wire logic              cur_done_i,
   input  wire logic              temp_done_i,
   input  wire logic              short_over_i,
   input  wire logic              short_delay_cap_pin_i,
   input  wire logic              crc_err_i,
   input  wire logic              clk_halt_i,
   input  wire logic              reg_access_i,
   output logic                   cell_conv_o,
   output logic [3:0]             cell_sel_o,
   output logic                   discard_o,
   output logic                   charge_enable_o,
   output logic                   discharge_enable_o,
   output logic                   irq_n_o
);
   typedef enum logic [1:0] {PEI_IDLE, PEI_CONV, PEI_NEXT} pei_scan_t;

   logic              power_save_bit;
   logic              cell_meas_start;
   logic              current_meas_start;
   logic              temp_meas_start;
   logic [W_WDP-1:0]  wdp;
   logic [W_SLT-1:0]  slt;
   logic [W_CNT-1:0]  cnt_set;
   logic [N_EV-1:0]   irq_en;
   logic [N_EV-1:0]   pend;
   logic [N_EV-1:0]   ev;
   pei_scan_t         scan_st;
   logic [3:0]        cell_idx;
   logic              scan_ovr;
   logic [W_CNT-1:0]  ov_cnt;
   logic [31:0]       tmr;
   logic [31:0]       wdt_cnt;
   logic              wdt_once;
   logic              scan_done;
   logic              scan_fire;
   logic              wdt_ovf;
   logic              ov_hit;
   logic              wr;
   logic              rd;

   // Byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction

   // Writes land at the edge where the master samples ack high
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   // Single-wait-state acknowledge; every address answers, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) wb_ack_o <= 1'b0;
      else       wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   // Read data registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (rd) begin
         unique case (wb_adr_i)
            A_CTRL:   wb_dat_o <= {22'h0, wdp, 2'h0, discharge_enable_o, charge_enable_o,
                                   temp_meas_start, current_meas_start, cell_meas_start,
                                   power_save_bit};
            A_OVSET:  wb_dat_o <= {24'h0, cnt_set, 2'h0, slt};
            A_IRQEN:  wb_dat_o <= {16'h0, irq_en};
            A_IRQPND: wb_dat_o <= {16'h0, pend};
            default:  wb_dat_o <= 32'h0;
         endcase
      end
   end

   // Control register; start bits self-clear when their measurement ends
   always_ff @(posedge clk_i) begin
      logic [31:0] m;
      m = merge({22'h0, wdp, 2'h0, discharge_enable_o, charge_enable_o, temp_meas_start,
                 current_meas_start, cell_meas_start, power_save_bit}, wb_dat_i, wb_sel_i);
      if (rst_i) begin
         power_save_bit     <= 1'b0;
         cell_meas_start    <= 1'b0;
         current_meas_start <= 1'b0;
         temp_meas_start    <= 1'b0;
         charge_enable_o    <= 1'b0;
         discharge_enable_o <= 1'b0;
         wdp                <= '0;
      end else begin
         if (wr && wb_adr_i == A_CTRL && !crc_err_i) begin // R13
            power_save_bit     <= m[B_PSAVE];
            cell_meas_start    <= m[B_CELL] & ~m[B_PSAVE];
            current_meas_start <= m[B_CUR] & ~m[B_PSAVE];
            temp_meas_start    <= m[B_TEMP] & ~m[B_PSAVE];
            charge_enable_o    <= m[B_CHG];   // R18
            discharge_enable_o <= m[B_DIS];
            wdp                <= m[B_WDP +: W_WDP];
         end
         // Start bit is set at every scan launch, automatic ones too; a host CTRL write mid-scan can clear it
         if (scan_fire)   cell_meas_start    <= 1'b1; // R3
         if (scan_done)   cell_meas_start    <= 1'b0;
         if (cur_done_i)  current_meas_start <= 1'b0;
         if (temp_done_i) temp_meas_start    <= 1'b0;
         // Protection wins over a same-cycle host write
         if (ov_hit) charge_enable_o <= 1'b0; // R11
         if (short_over_i && short_delay_cap_pin_i || clk_halt_i
             || (wdt_ovf && wdt_once)) begin // R12 R14 R16
            charge_enable_o    <= 1'b0;
            discharge_enable_o <= 1'b0;
         end
      end
   end

   // Setup and enable registers
   always_ff @(posedge clk_i) begin
      logic [31:0] ms;
      logic [31:0] me;
      ms = merge({24'h0, cnt_set, 2'h0, slt}, wb_dat_i, wb_sel_i);
      me = merge({16'h0, irq_en}, wb_dat_i, wb_sel_i);
      if (rst_i) begin
         slt     <= '0;
         cnt_set <= '0;
         irq_en  <= '0;
      end else if (wr && !crc_err_i) begin
         if (wb_adr_i == A_OVSET) begin
            slt     <= ms[B_SLT +: W_SLT];
            cnt_set <= ms[B_CNT +: W_CNT];
         end
         if (wb_adr_i == A_IRQEN)
            irq_en <= me[N_EV-1:0] & EV_MASK; // R7
      end
   end

   // Cell scan sequencer: host start, or periodic in power save
   assign scan_fire = (scan_st == PEI_IDLE)
                      && ((cell_meas_start && !power_save_bit)
                          || (power_save_bit && tmr == 32'h0)); // R1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_st  <= PEI_IDLE;
         cell_idx <= '0;
         tmr      <= '0;
      end else begin
         unique case (scan_st)
            PEI_IDLE: begin
               if (power_save_bit && tmr != 32'h0) tmr <= tmr - 32'h1;
               if (scan_fire) begin
                  cell_idx <= '0;
                  scan_st  <= PEI_CONV;
                  tmr      <= 32'(SCAN_UNIT) * (32'(slt) + 32'h1);
               end
            end
            PEI_CONV: if (cell_done_i) scan_st <= PEI_NEXT;
            // Leaving power save does not abort here; the scan runs to the end
            PEI_NEXT: begin // R2
               if (cell_idx == 4'(NUM_CELLS - 1)) scan_st <= PEI_IDLE;
               else begin
                  cell_idx <= cell_idx + 4'h1;
                  scan_st  <= PEI_CONV;
               end
            end
         endcase
      end
   end
   assign scan_done   = scan_st == PEI_NEXT && cell_idx == 4'(NUM_CELLS - 1);
   assign cell_conv_o = scan_st == PEI_CONV;
   assign cell_sel_o  = cell_idx;

   // Any cell over threshold during the scan marks it overvoltage
   always_ff @(posedge clk_i) begin
      if (rst_i) scan_ovr <= 1'b0;
      else if (scan_fire) scan_ovr <= 1'b0;
      else if (scan_st == PEI_CONV && cell_done_i && cell_over_i) scan_ovr <= 1'b1;
   end

   // Consecutive overvoltage scan counter; a clean scan restarts it
   // A zero delay count never trips, even when the counter wraps
   assign ov_hit = scan_done && scan_ovr && cnt_set != '0 && (ov_cnt + 4'h1 == cnt_set);
   always_ff @(posedge clk_i) begin
      if (rst_i) ov_cnt <= '0;
      else if (scan_done) ov_cnt <= scan_ovr ? ov_cnt + 4'h1 : '0; // R11
   end

   // Watchdog; halted in power save, kept alive only by CRC-clean accesses
   assign wdt_ovf = !power_save_bit && wdt_cnt >= WDT_UNIT * (32'(wdp) + 32'h1); // R15
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_cnt  <= '0;
         wdt_once <= 1'b0;
      end else if ((reg_access_i && !crc_err_i) || wdt_ovf) begin // R17
         wdt_cnt  <= '0;
         wdt_once <= wdt_ovf;
      end else if (!power_save_bit) begin
         wdt_cnt <= wdt_cnt + 32'h1;
      end
   end

   assign discard_o = crc_err_i; // R13

   // Event vector; power-save scans also report completion
   always_comb begin
      ev         = '0;
      ev[E_CELL] = scan_done;          // R4 R8
      ev[E_CUR]  = cur_done_i;         // R9
      ev[E_TEMP] = temp_done_i;        // R10
      ev[E_OV]   = ov_hit;
      ev[E_SC]   = short_over_i && short_delay_cap_pin_i; // R12
      ev[E_CRC]  = crc_err_i;
      ev[E_CLK]  = clk_halt_i;         // R14
      ev[E_WDT]  = wdt_ovf;
   end

   // Sticky pending bits, set beats write-one-to-clear
   always_ff @(posedge clk_i) begin
      logic [31:0] clr;
      clr = merge(32'h0, wb_dat_i, wb_sel_i);
      if (rst_i) pend <= '0;
      else if (wr && wb_adr_i == A_IRQPND && !crc_err_i)
         pend <= (pend & ~clr[N_EV-1:0]) | ev; // R7
      else pend <= pend | ev;
   end

   // Level interrupt, active low
   assign irq_n_o = ~|(pend & irq_en); // R6 R19

   property p_ev_sticky;
      @(posedge clk_i) disable iff (rst_i) (ev & irq_en) != 0 |=> !irq_n_o;
   endproperty
   a_ev_sticky: assert property (p_ev_sticky) else $error("enabled event did not assert irq"); // R6
   property p_irq_hold;
      @(posedge clk_i) disable iff (rst_i) (pend & irq_en) != 0 |-> !irq_n_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq released while pending"); // R19
   property p_cell_done;
      @(posedge clk_i) disable iff (rst_i) scan_done |=> pend[E_CELL] && !cell_meas_start;
   endproperty
   a_cell_done: assert property (p_cell_done) else $error("cell completion not flagged"); // R8
   property p_ov_chg;
      @(posedge clk_i) disable iff (rst_i) ov_hit |=> !charge_enable_o && pend[E_OV];
   endproperty
   a_ov_chg: assert property (p_ov_chg) else $error("overvoltage kept charge on"); // R11
   property p_sc;
      @(posedge clk_i) disable iff (rst_i)
         short_over_i && short_delay_cap_pin_i |=> !charge_enable_o && !discharge_enable_o;
   endproperty
   a_sc: assert property (p_sc) else $error("short did not clear FETs"); // R12
   property p_clk;
      @(posedge clk_i) disable iff (rst_i)
         clk_halt_i |=> pend[E_CLK] && !charge_enable_o && !discharge_enable_o;
   endproperty
   a_clk: assert property (p_clk) else $error("clock halt not handled"); // R14
   property p_wdt;
      @(posedge clk_i) disable iff (rst_i) wdt_ovf |=> pend[E_WDT] && wdt_cnt == 0;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog overflow not flagged"); // R15
   property p_wdt2;
      @(posedge clk_i) disable iff (rst_i)
         wdt_ovf && wdt_once |=> !charge_enable_o && !discharge_enable_o;
   endproperty
   a_wdt2: assert property (p_wdt2) else $error("double overflow kept FETs on"); // R16
   property p_crc;
      @(posedge clk_i) disable iff (rst_i)
         crc_err_i && !wdt_ovf && !power_save_bit |=> wdt_cnt == $past(wdt_cnt) + 1;
   endproperty
   a_crc: assert property (p_crc) else $error("crc error restarted watchdog"); // R17
   property p_ps_run;
      @(posedge clk_i) disable iff (rst_i)
         scan_st == PEI_NEXT && cell_idx != 4'(NUM_CELLS - 1) |=> scan_st == PEI_CONV;
   endproperty
   a_ps_run: assert property (p_ps_run) else $error("scan aborted before last cell"); // R2
   c_ps_scan: cover property (@(posedge clk_i) disable iff (rst_i) power_save_bit && scan_done);
   c_ov: cover property (@(posedge clk_i) disable iff (rst_i) ov_hit);
   c_wdt2: cover property (@(posedge clk_i) disable iff (rst_i) wdt_ovf && wdt_once);
endmodule
`default_nettype wire

// file: verification/pei_meas_model.sv
// Measurement engine stand-in that answers cell conversion requests from the core.
// Assumes cell_conv_i stays high until the core moves to the next cell or stops.
`timescale 1ns/100ps
`default_nettype none
module pei_meas_model #(
   parameter int DLY = 3
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic cell_conv_i,
   input  wire logic over_i,
   output logic      cell_done_o,
   output logic      cell_over_o
);
   int cnt;
   // Fixed conversion time per cell, done is a one-cycle pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !cell_conv_i || cell_done_o) begin
         cnt         <= 0;
         cell_done_o <= 1'b0;
      end else if (cnt == DLY - 1) begin
         cell_done_o <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
   // Inverted outside done so a stale level never helps the core
   assign cell_over_o = cell_done_o ? over_i : !over_i;
endmodule
`default_nettype wire

// file: verification/tb_protection_event_interrupt_logic.sv
// Self-checking bench for the event and interrupt core, with a pending/enable model.
// Assumes the package constants and a one-cycle Wishbone answer from the core.
`timescale 1ns/100ps
`default_nettype none
module tb_protection_event_interrupt_logic;
   import pei_pkg::*;
   localparam int WU = 50;
   logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, sc, sd, ka, acc;
   logic        cdone, cell_ov, ov_lvl, cell_conv_o, discard_o, chg, dis, irq_n_o;
   logic [3:0]  wb_adr_i, wb_sel_i, pul, cell_sel_o;
   logic [31:0] wb_dat_i, wb_dat_o, q, rnd;
   int          err_count, checks, cyc, pend_m, en_m, n;
   int          eb[4] = '{E_CUR, E_TEMP, E_CRC, E_CLK};
   pei_core #(.SCAN_UNIT(20), .WDT_UNIT(WU)) pei_core_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cell_done_i(cdone), .cell_over_i(cell_ov),
      .cur_done_i(pul[0]), .temp_done_i(pul[1]), .short_over_i(sc),
      .short_delay_cap_pin_i(sd), .crc_err_i(pul[2]), .clk_halt_i(pul[3]),
      .reg_access_i(acc), .cell_conv_o(cell_conv_o), .cell_sel_o(cell_sel_o),
      .discard_o(discard_o), .charge_enable_o(chg), .discharge_enable_o(dis),
      .irq_n_o(irq_n_o));
   pei_meas_model pei_meas_model_i (.clk_i(clk_i), .rst_i(rst_i), .cell_conv_i(cell_conv_o),
      .over_i(ov_lvl), .cell_done_o(cdone), .cell_over_o(cell_ov));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ci();
      chk("irq_n", irq_n_o, (pend_m & en_m) == 0);
   endtask
   // Classic single cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o;
      if (k == 50) begin
         err_count++;
         summarize();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic waitp(input int b);
      n = 0;
      do begin
         wb(1'b0, A_IRQPND, 0);
         n++;
      end while (q[b] !== 1'b1 && n < 400);
   endtask
   task automatic summarize();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Host keep-alive on the SPI access strobe, plus the hang limit
   always @(posedge clk_i) begin
      cyc++;
      acc <= ka && (cyc % 8 == 0);
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      rst_i <= 1'b1; wb_we_i <= 1'b0; wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
      wb_adr_i <= 4'h0; wb_sel_i <= 4'hF; wb_dat_i <= 32'h0; pul <= 4'h0;
      sc <= 1'b0; sd <= 1'b0; ka <= 1'b1; ov_lvl <= 1'b0;
      rnd = 32'h92A2;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset contents and unaligned holes read as zero
      for (int a = 0; a < 16; a += 2) begin
         wb(1'b0, a[3:0], 0);
         chk("reset_rd", q, 0);
      end
      rnd = lfsr(rnd);
      wb(1'b1, A_IRQEN, rnd);
      wb(1'b1, 4'h2, ~rnd);
      wb(1'b0, A_IRQEN, 0);
      chk("enable_rd", q, rnd & EV_MASK);
      wb(1'b1, A_IRQEN, 0);
      wb(1'b1, A_CTRL, 32'h30);
      chk("fets_on", {chg, dis}, 2'b11);
      // Each simple event: masked, then unmasked, then cleared
      for (int k = 0; k < 4; k++) begin
         pul[k] <= 1'b1;
         @(posedge clk_i);
         chk("discard", discard_o, k == 2);
         pul[k] <= 1'b0;
         pend_m |= 1 << eb[k];
         repeat (2) @(posedge clk_i);
         ci();
         wb(1'b0, A_IRQPND, 0);
         chk("pending", q, pend_m);
         en_m = 1 << eb[k];
         wb(1'b1, A_IRQEN, en_m);
         ci();
         pend_m = 0;
         wb(1'b1, A_IRQPND, 1 << eb[k]);
         ci();
      end
      chk("halt_fets", {chg, dis}, 2'b00);
      // Short circuit needs both the threshold and the delay pin
      wb(1'b1, A_CTRL, 32'h30);
      sc <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("short_half", {chg, dis}, 2'b11);
      sd <= 1'b1;
      repeat (3) @(posedge clk_i);
      sc <= 1'b0;
      sd <= 1'b0;
      chk("short_fets", {chg, dis}, 2'b00);
      wb(1'b0, A_IRQPND, 0);
      chk("short_pnd", q, 1 << E_SC);
      wb(1'b1, A_IRQPND, 32'hFFFF);
      // Host-started cell scan
      wb(1'b1, A_CTRL, 32'h32);
      waitp(E_CELL);
      chk("cell_pnd", q, 1 << E_CELL);
      wb(1'b1, A_IRQPND, 32'hFFFF);
      // Power-save scans with every cell over, delay count two
      ov_lvl <= 1'b1;
      wb(1'b1, A_OVSET, 2 << B_CNT);
      wb(1'b1, A_IRQEN, 0);
      wb(1'b1, A_CTRL, 32'h31);
      waitp(E_OV);
      chk("ov_pnd", q, (1 << E_OV) | (1 << E_CELL));
      chk("ov_fets", {chg, dis}, 2'b01);
      ov_lvl <= 1'b0;
      wb(1'b1, A_CTRL, 32'h30);
      n = 0;
      do begin
         wb(1'b0, A_CTRL, 0);
         n++;
      end while (q[B_CELL] !== 1'b0 && n < 100);
      chk("scan_end", {q[B_CELL], cell_conv_o}, 2'b00);
      wb(1'b1, A_IRQPND, 32'hFFFF);
      // Watchdog: first overflow interrupts, second clears both enables
      en_m = 1 << E_WDT;
      wb(1'b1, A_IRQEN, en_m);
      ka <= 1'b0;
      n = 0;
      while (irq_n_o !== 1'b0 && n < WU * 3) begin
         @(posedge clk_i);
         n++;
      end
      pend_m = en_m;
      ci();
      chk("wdt_one", {chg, dis}, 2'b11);
      repeat (WU + 5) @(posedge clk_i);
      chk("wdt_two", {chg, dis}, 2'b00);
      ka <= 1'b1;
      summarize();
   end
endmodule
`default_nettype wire
